// [inc/token_host_defs.svh]
// Purpose: constants for the token-flag port controller
// Assumes: one port of the dual-port memory, 18-bit data, 13-bit address
// Notes: times in ns, counts derived from the 200 MHz clock
`ifndef TOKEN_HOST_DEFS_SVH
`define TOKEN_HOST_DEFS_SVH
`define TOKEN_COUNT 8
`define TOKEN_IDX_W 3
`define ADDR_W 13
`define DATA_W 18
`define CLK_PERIOD_NS 5
`define STROBE_NS 20
`define STROBE_CYC (((`STROBE_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define GAP_NS 10
`define GAP_CYC (((`GAP_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define CNT_W 4
`define ZERO_ADDR 13'h0000
`define ZERO_DATA 18'h00000
`define ALL_ONES_DATA 18'h3ffff
`endif

// [inc/token_host_pkg.sv]
// Purpose: types for the token-flag port controller
// Assumes: token_host_defs.svh constants
// Notes: pin group travels as one packed struct
`include "token_host_defs.svh"
package token_host_pkg;
   typedef enum logic [1:0] {
      cmd_take,
      cmd_give,
      cmd_peek
   } cmd_type;
   typedef struct packed {
      logic token_select_n;
      logic mem_select_n;
      logic rw_n;
      logic out_enable_n;
      logic [`ADDR_W-1:0] addr;
      logic [`DATA_W-1:0] dout;
      logic dout_en;
   } pins_type;
endpackage : token_host_pkg

// [rtl/cycle_timer.sv]
// Purpose: down counter that times strobe and gap phases
// Assumes: load and count share the clock enable of the parent
// Notes: done is high while the count is zero
`timescale 1ns/1ps
`include "token_host_defs.svh"
module cycle_timer (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic load_i,
   input wire logic [`CNT_W-1:0] value_i,
   output logic done_o
);
   logic [`CNT_W-1:0] count;
   logic [`CNT_W-1:0] next_count;
   always_comb begin
      next_count = count;
      if (load_i) begin
         next_count = value_i;
      end else if (count != '0) begin
         next_count = count - 1'b1;
      end
   end
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         count <= '0;
      end else if (ce_i) begin
         count <= next_count;
      end
   end
   assign done_o = (count == '0);
endmodule : cycle_timer

// [rtl/token_host.sv]
// Purpose: drives one port of the dual-port memory's token flags
// Assumes: pin inputs synchronous to clk_i; one command at a time
// Notes: take = write zero then read back; give = write one
`timescale 1ns/1ps
`include "token_host_defs.svh"
module token_host (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic cmd_valid_i,
   input wire token_host_pkg::cmd_type cmd_i,
   input wire logic [`TOKEN_IDX_W-1:0] token_index_i,
   input wire logic give_up_i,
   input wire logic [`DATA_W-1:0] din_i,
   output logic ready_o,
   output logic done_o,
   output logic granted_o,
   output logic [`TOKEN_IDX_W-1:0] done_index_o,
   output token_host_pkg::pins_type pins_o
);
   import token_host_pkg::*;
   typedef enum logic [2:0] {
      st_init,
      st_idle,
      st_write,
      st_gap,
      st_read,
      st_finish
   } state_type;
   state_type state, next_state;
   cmd_type cmd, next_cmd;
   logic [`TOKEN_IDX_W-1:0] index, next_index;
   logic init_pending, next_init_pending;
   logic ready, next_ready;
   logic done, next_done;
   logic granted, next_granted;
   pins_type pins, next_pins;
   logic load;
   logic [`CNT_W-1:0] load_value;
   logic timer_done;
   logic read_bit;

   cycle_timer u_timer (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .ce_i(ce_i),
      .load_i(load),
      .value_i(load_value),
      .done_o(timer_done)
   );

   // Flag is spread over all bits; bit zero is enough
   assign read_bit = din_i[0];

   always_comb begin
      next_state = state;
      next_cmd = cmd;
      next_index = index;
      next_init_pending = init_pending;
      next_ready = 1'b0;
      next_done = 1'b0;
      next_granted = granted;
      next_pins = pins;
      load = 1'b0;
      load_value = `CNT_W'(`STROBE_CYC);
      case (state)
         st_init: begin
            // Free every flag from our side after reset
            next_cmd = cmd_give;
            next_state = st_write;
            next_init_pending = 1'b1;
            load = 1'b1;
            next_pins.token_select_n = 1'b0;
            next_pins.mem_select_n = 1'b1;
            next_pins.rw_n = 1'b0;
            next_pins.addr = {{(`ADDR_W-`TOKEN_IDX_W){1'b0}}, index};
            next_pins.dout = `ALL_ONES_DATA;
            next_pins.dout_en = 1'b1;
         end
         st_idle: begin
            next_ready = 1'b1;
            if (cmd_valid_i && ready) begin
               next_ready = 1'b0;
               next_cmd = cmd_i;
               next_index = token_index_i;
               load = 1'b1;
               next_pins.token_select_n = 1'b0;
               next_pins.mem_select_n = 1'b1;
               next_pins.addr = {{(`ADDR_W-`TOKEN_IDX_W){1'b0}}, token_index_i};
               if (cmd_i == cmd_peek) begin
                  next_state = st_read;
                  next_pins.rw_n = 1'b1;
                  next_pins.out_enable_n = 1'b0;
                  next_pins.dout_en = 1'b0;
               end else begin
                  next_state = st_write;
                  next_pins.rw_n = 1'b0;
                  next_pins.dout_en = 1'b1;
                  // Zero requests, one releases; only bit zero matters
                  next_pins.dout = (cmd_i == cmd_take) ? `ZERO_DATA : `ALL_ONES_DATA;
               end
            end
         end
         st_write: begin
            if (timer_done) begin
               next_state = st_gap;
               load_value = `CNT_W'(`GAP_CYC);
               load = 1'b1;
               next_pins.token_select_n = 1'b1;
               next_pins.rw_n = 1'b1;
               next_pins.dout_en = 1'b0;
            end
         end
         st_gap: begin
            // Select and enable lifted between accesses so the read relatches
            if (timer_done) begin
               if (cmd == cmd_take) begin
                  // Write then read back, never the other way round
                  next_state = st_read;
                  load = 1'b1;
                  next_pins.token_select_n = 1'b0;
                  next_pins.out_enable_n = 1'b0;
               end else if (init_pending) begin
                  next_index = index + 1'b1;
                  next_state = (index == `TOKEN_IDX_W'(`TOKEN_COUNT - 1)) ? st_idle : st_init;
                  next_init_pending = (index != `TOKEN_IDX_W'(`TOKEN_COUNT - 1));
               end else begin
                  next_state = st_finish;
                  next_granted = 1'b0;
               end
            end
         end
         st_read: begin
            if (timer_done) begin
               next_pins.token_select_n = 1'b1;
               next_pins.out_enable_n = 1'b1;
               load_value = `CNT_W'(`GAP_CYC);
               load = 1'b1;
               next_granted = ~read_bit;
               if (cmd == cmd_take && read_bit && give_up_i) begin
                  // Withdraw a failed request so the flag cannot hang
                  next_cmd = cmd_give;
                  next_state = st_gap;
                  next_pins.token_select_n = 1'b0;
                  next_pins.rw_n = 1'b0;
                  next_pins.dout = `ALL_ONES_DATA;
                  next_pins.dout_en = 1'b1;
                  load_value = `CNT_W'(`STROBE_CYC);
                  next_state = st_write;
               end else if (cmd == cmd_take && read_bit) begin
                  // Failed: poll again after a gap
                  next_state = st_gap;
               end else begin
                  next_state = st_finish;
               end
            end
         end
         st_finish: begin
            if (timer_done) begin
               next_done = 1'b1;
               next_state = st_idle;
            end
         end
         default: begin
            next_state = st_idle;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state <= st_init;
         cmd <= cmd_give;
         index <= '0;
         init_pending <= 1'b1;
         ready <= 1'b0;
         done <= 1'b0;
         granted <= 1'b0;
         pins <= '{token_select_n: 1'b1, mem_select_n: 1'b1, rw_n: 1'b1,
                   out_enable_n: 1'b1, addr: `ZERO_ADDR, dout: `ZERO_DATA,
                   dout_en: 1'b0};
      end else if (ce_i) begin
         state <= next_state;
         cmd <= next_cmd;
         index <= next_index;
         init_pending <= next_init_pending;
         ready <= next_ready;
         done <= next_done;
         granted <= next_granted;
         pins <= next_pins;
      end
   end

   assign ready_o = ready;
   assign done_o = done;
   assign granted_o = granted;
   assign done_index_o = index;
   assign pins_o = pins;

   chk_mem_stays_off: assert property (@(posedge clk_i) disable iff (!resetn_i)
      !pins_o.token_select_n |-> pins_o.mem_select_n)
      else $error("memory select low during token access");
   // Withdraw write may follow a read with select held, so only read starts are checked
   chk_read_gap: assert property (@(posedge clk_i) disable iff (!resetn_i)
      $fell(pins_o.out_enable_n) |-> $past(pins_o.token_select_n))
      else $error("read started without lifting select");
   sequence take_write_s;
      !pins_o.token_select_n && !pins_o.rw_n && pins_o.dout_en && !pins_o.dout[0];
   endsequence
   sequence read_back_s;
      !pins_o.token_select_n && !pins_o.out_enable_n && pins_o.rw_n;
   endsequence
   // Loose bound because a low clock enable stretches the gap
   chk_write_then_read: assert property (@(posedge clk_i) disable iff (!resetn_i)
      take_write_s ##1 pins_o.token_select_n |-> ##[1:100] read_back_s)
      else $error("take write not followed by read back");
   chk_addr_high_zero: assert property (@(posedge clk_i) disable iff (!resetn_i)
      !pins_o.token_select_n |-> (pins_o.addr[`ADDR_W-1:`TOKEN_IDX_W] == '0))
      else $error("upper address bits set during token access");
   chk_granted_read: assert property (@(posedge clk_i) disable iff (!resetn_i)
      $rose(granted_o) |-> !$past(pins_o.out_enable_n))
      else $error("grant raised without a read back");
   chk_init_ones: assert property (@(posedge clk_i) disable iff (!resetn_i)
      (init_pending && !pins_o.rw_n) |-> pins_o.dout[0])
      else $error("init wrote zero to a flag");
endmodule : token_host

// [test/token_device_model.sv]
// Purpose: far-side token flags, left port on host pins, right port on bench strobes
// Assumes: right side gives one-cycle write strobes
// Notes: tie goes left; released data lines toggle so stale values never pass
`timescale 1ns/1ps
`include "token_host_defs.svh"
module token_device_model (
   input wire logic clk_i,
   input wire token_host_pkg::pins_type pins_i,
   input wire logic r_wr_i,
   input wire logic [2:0] r_idx_i,
   input wire logic r_bit_i,
   output logic [`DATA_W-1:0] din_o,
   output logic [7:0] r_view_o
);
   import token_host_pkg::*;
   logic [7:0] req_l = 8'h00; // Power-up: left owns all, so a skipped init shows
   logic [7:0] req_r = 8'hff;
   logic [7:0] own_l = 8'hff;
   logic [7:0] own_r = 8'h00;
   logic latch = 1'b1;
   logic rd_prev = 1'b0;
   logic [`DATA_W-1:0] idle = '0;
   wire sel = !pins_i.token_select_n && pins_i.mem_select_n;
   wire rd_on = sel && !pins_i.out_enable_n;
   assign din_o = (rd_on && rd_prev) ? {`DATA_W{latch}} : idle;
   assign r_view_o = ~own_r;
   always_ff @(posedge clk_i) begin
      logic [7:0] nl;
      logic [7:0] nr;
      nl = req_l;
      nr = req_r;
      if (sel && !pins_i.rw_n) begin
         nl[pins_i.addr[2:0]] = pins_i.dout[0];
      end
      if (r_wr_i) begin
         nr[r_idx_i] = r_bit_i;
      end
      for (int k = 0; k < 8; k++) begin
         if (own_l[k] && nl[k]) begin
            own_l[k] <= 1'b0;
            own_r[k] <= !nr[k];
         end else if (own_r[k] && nr[k]) begin
            own_r[k] <= 1'b0;
            own_l[k] <= !nl[k];
         end else if (!own_l[k] && !own_r[k]) begin
            own_l[k] <= !nl[k];
            own_r[k] <= nl[k] && !nr[k];
         end
      end
      req_l <= nl;
      req_r <= nr;
      rd_prev <= rd_on;
      if (rd_on && !rd_prev) begin
         latch <= !own_l[pins_i.addr[2:0]];
      end
      idle <= ~idle;
   end
endmodule : token_device_model

// [test/dual_port_semaphore_flags_tb_top.sv]
// Purpose: corner and random runs of the token host against the flag model
// Assumes: bench mirrors ownership of both sides
// Notes: right side driven directly; clock enable drops at random
`timescale 1ns/1ps
`include "token_host_defs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
   $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end
module dual_port_semaphore_flags_tb_top;
   import token_host_pkg::*;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic ce_i = 1'b1;
   logic cmd_valid_i = 1'b0;
   cmd_type cmd_i = cmd_peek;
   logic [2:0] token_index_i = 3'h0;
   logic give_up_i = 1'b0;
   logic [`DATA_W-1:0] din_i;
   logic ready_o, done_o, granted_o;
   logic [2:0] done_index_o;
   pins_type pins_o;
   logic r_wr = 1'b0;
   logic [2:0] r_idx = 3'h0;
   logic r_bit = 1'b1;
   logic [7:0] r_view, left_has = 8'h00, right_has = 8'h00, rq_r = 8'hff;
   logic [31:0] rng = 32'h34, ce_rng = 32'h34;
   int err_total = 0, comparisons = 0, cycles = 0;
   token_host DUT (.clk_i, .resetn_i, .ce_i, .cmd_valid_i, .cmd_i, .token_index_i,
      .give_up_i, .din_i, .ready_o, .done_o, .granted_o, .done_index_o, .pins_o);
   token_device_model device (.clk_i, .pins_i(pins_o), .r_wr_i(r_wr), .r_idx_i(r_idx),
      .r_bit_i(r_bit), .din_o(din_i), .r_view_o(r_view));
   initial forever #2.5 clk_i = ~clk_i;
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xorshift
   // Left loses only when the right holds it and the host gives up
   function automatic logic take_wins(input logic right_owned, input logic quit);
      return !(right_owned && quit);
   endfunction : take_wins
   task automatic final_report();
      if (err_total == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : final_report
   task automatic right_write(input logic [2:0] k, input logic b);
      {r_idx, r_bit, r_wr} <= {k, b, 1'b1};
      rq_r[k] = b;
      right_has[k] = b ? 1'b0 : (right_has[k] | !left_has[k]);
      @(posedge clk_i);
      r_wr <= 1'b0;
      @(negedge clk_i);
      `CHK(r_view[k], !right_has[k])
      @(posedge clk_i);
   endtask : right_write
   task automatic host_cmd(input cmd_type c, input logic [2:0] k, input logic quit);
      int n;
      logic ok;
      logic win;
      n = 0;
      {cmd_i, token_index_i, give_up_i, cmd_valid_i} <= {c, k, quit, 1'b1};
      {r_idx, r_bit} <= {k, 1'b1};
      do begin
         @(negedge clk_i);
         ok = ready_o === 1'b1 && ce_i;
         @(posedge clk_i);
      end while (!ok);
      cmd_valid_i <= 1'b0;
      // A polling host would hang forever, so the right side lets go mid-poll
      forever begin
         @(negedge clk_i);
         n++;
         if (done_o === 1'b1) break;
         @(posedge clk_i);
         r_wr <= n == 60 && right_has[k] && !quit && c == cmd_take;
      end
      win = take_wins(right_has[k], quit);
      case (c)
         cmd_take: begin
            `CHK(granted_o, win)
            rq_r[k] = rq_r[k] | (right_has[k] & !quit);
            right_has[k] = right_has[k] & quit;
            left_has[k] = win;
         end
         cmd_give: begin
            left_has[k] = 1'b0;
            right_has[k] = !rq_r[k];
         end
         default: `CHK(granted_o, left_has[k])
      endcase
      `CHK(r_view[k], !right_has[k])
      `CHK(done_index_o, k)
      @(posedge clk_i);
   endtask : host_cmd
   always @(posedge clk_i) begin
      ce_rng <= xorshift(ce_rng);
      ce_i <= ce_rng[2:0] != 3'h0;
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         err_total++;
         final_report();
      end
   end
   always @(negedge clk_i) begin
      if (resetn_i && !pins_o.token_select_n) begin
         `CHK(pins_o.mem_select_n, 1'b1)
         `CHK(pins_o.addr[12:3], 10'h000)
         `CHK({pins_o.dout_en, pins_o.out_enable_n}, {!pins_o.rw_n, !pins_o.rw_n})
      end
   end
   initial begin
      int k;
      repeat (6) @(posedge clk_i);
      resetn_i <= 1'b1;
      for (k = 0; k < 8; k++) right_write(k[2:0], 1'b1);
      for (k = 0; k < 8; k++) host_cmd(cmd_peek, k[2:0], 1'b0);
      right_write(3'h5, 1'b0);
      host_cmd(cmd_take, 3'h5, 1'b1);
      host_cmd(cmd_take, 3'h5, 1'b0);
      right_write(3'h5, 1'b0);
      host_cmd(cmd_give, 3'h5, 1'b0);
      right_write(3'h5, 1'b1);
      repeat (150) begin
         rng = xorshift(rng);
         if (rng[1:0] == 2'h3) begin
            right_write(rng[6:4], rng[8]);
         end else begin
            host_cmd((rng[3:2] == 2'h3) ? cmd_peek : cmd_type'(rng[3:2]), rng[6:4], rng[7]);
         end
      end
      final_report();
   end
endmodule : dual_port_semaphore_flags_tb_top
